// >>> gpio_defines.vh
// What this block does
// (RULE_01) every pin keeps its own three-bit drive mode, chosen independently.
// (RULE_02) modes 0 and 1 keep all drivers off whatever the output value.
// (RULE_03) mode 2: pull-up or strong low; mode 3: strong high or pull-down.
// (RULE_04) mode 4: high impedance for one, strong low for zero.
// (RULE_05) mode 5: strong high for one, high impedance for zero.
// (RULE_06) mode 6 drives strongly both ways; mode 7 pulls both ways.
// (RULE_07) drive value is the output register bit, or routed signal when bypassed.
// (RULE_08) special pins in regulated output mode get no resistive drive.
// (RULE_09) usb-capable pins use only a drive-enable and a pull-up-enable bit.
// (RULE_10) usb pins: zero is strong low; one is strong, pulled or floating.
// (RULE_11) in usb operation those two bits have no effect.
// (RULE_12) port-wide mode writes leave the usb pins' mode bits unchanged.
// (RULE_13) each pin interrupts on rising, falling or both edges as selected.
// (RULE_14) pin interrupts combine into one request line per port.
// (RULE_15) separate pin-state read register and output-value write register.
// (RULE_16) settings reachable per port (bit per pin) and per pin (gathered); here interrupt type is pin form only, regulated mode port form only.
// (RULE_17) drive mode after reset is programmable per port.
// (RULE_18) interrupt selection has a disabled setting.
// (RULE_19) each event sets the pin's status bit and requests the port interrupt.
// (RULE_20) routed output enable switches between digital high-z and chosen mode.
// (RULE_21) reset drive state is analog high impedance, input buffer off.
// (RULE_22) pin inputs are synchronised before edge comparison.
`ifndef GPIO_DEFINES_VH
`define GPIO_DEFINES_VH

// port-form register offsets, low nibble; bit 6 picks the port
`define OFS_OUTPUT_VALUE  4'h0
`define OFS_DM_BIT0       4'h1
`define OFS_DM_BIT1       4'h2
`define OFS_DM_BIT2       4'h3
`define OFS_BYPASS        4'h4
`define OFS_BIDIR_ENABLE  4'h5
`define OFS_PIN_STATE     4'h6
`define OFS_INT_STATUS    4'h7
`define OFS_SIO_REGULATED 4'h8
// address fields
`define ADDR_PORT_BIT     6
`define ADDR_PINFORM_BIT  4
// pin-form field positions
`define PF_OUT_BIT        0
`define PF_DM_LSB         1
`define PF_BYP_BIT        4
`define PF_BIE_BIT        5
`define PF_IT_LSB         6
// drive modes
`define DM_ANALOG_HIZ     3'h0
`define DM_DIGITAL_HIZ    3'h1
`define DM_PULL_UP        3'h2
`define DM_PULL_DOWN      3'h3
`define DM_OD_LOW         3'h4
`define DM_OD_HIGH        3'h5
`define DM_STRONG         3'h6
`define DM_PULL_BOTH      3'h7
// interrupt type encodings
`define IT_DISABLED       2'h0
`define IT_RISING         2'h1
`define IT_FALLING        2'h2
`define IT_BOTH           2'h3
// pins 14 and 15 are the usb-capable pair
`define USB_PIN_FIRST     14

`endif

// >>> gpio_pin_drive_control.v
`timescale 1ns/1ns
`include "gpio_defines.vh"

module gpio_pin_drive_control (
  input  wire        CLOCK,
  input  wire        RST_N,
  input  wire [7:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  input  wire [2:0]  RESET_MODE_A,
  input  wire [2:0]  RESET_MODE_B,
  input  wire        USB_MODE,
  input  wire [15:0] PIN_IN,
  input  wire [15:0] ROUTED_OUT,
  input  wire [15:0] ROUTED_OE,
  output reg  [15:0] STRONG_HIGH,
  output reg  [15:0] STRONG_LOW,
  output reg  [15:0] PULL_UP,
  output reg  [15:0] PULL_DOWN,
  output reg  [15:0] INPUT_BUF_EN,
  output reg  [15:0] PIN_STATE,
  output reg  [1:0]  IRQ
);

  reg  [15:0] output_value_reg;
  reg  [15:0] dm0_reg;
  reg  [15:0] dm1_reg;
  reg  [15:0] dm2_reg;
  reg  [15:0] bypass_reg;
  reg  [15:0] bidir_enable_reg;
  reg  [15:0] sio_regulated_reg;
  reg  [15:0] it0_reg;
  reg  [15:0] it1_reg;
  reg  [15:0] status_reg;
  reg  [15:0] status_next;
  reg  [15:0] sync1_reg;
  reg  [15:0] sync2_reg;
  reg  [15:0] prev_reg;
  reg         init_done_reg;
  reg  [7:0]  rdata_next;
  wire [15:0] hi_next;
  wire [15:0] lo_next;
  wire [15:0] pu_next;
  wire [15:0] pd_next;
  wire [15:0] ibuf_next;
  wire [15:0] event_vec;
  reg  [15:0] clear_vec;
  genvar      g;

  wire        port_sel  = ADDR[`ADDR_PORT_BIT];
  wire        pin_form  = ADDR[`ADDR_PINFORM_BIT];
  wire [3:0]  offset    = ADDR[3:0];
  wire [3:0]  pin_index = {port_sel, ADDR[2:0]};
  wire        pin_hit   = pin_form && (ADDR[3] == 1'b0) && (ADDR[7] == 1'b0) && (ADDR[5] == 1'b0);
  wire        port_hit  = !pin_form && (ADDR[7] == 1'b0) && (ADDR[5] == 1'b0);
  wire [7:0]  port_lane = port_sel ? 8'hff : 8'h00;
  wire [15:0] port_mask = {port_lane, ~port_lane};
  // usb pair bits are masked out of port-wide mode writes
  wire [15:0] usb_mask  = 16'hc000;

  // two-stage synchroniser plus one history stage for edge compare
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
      prev_reg  <= 16'h0000;
    end else begin
      sync1_reg <= PIN_IN;
      sync2_reg <= sync1_reg; // [RULE_22]
      prev_reg  <= sync2_reg;
    end
  end

  // edge qualification per pin; type 0 never fires
  generate
    for (g = 0; g < 16; g = g + 1) begin : edge_qual
      wire       rise  = sync2_reg[g] & ~prev_reg[g];
      wire       fall  = ~sync2_reg[g] & prev_reg[g];
      wire [1:0] itype = {it1_reg[g], it0_reg[g]};
      reg        edge_hit;
      // compare against the history stage only, never the first flop
      always @* begin
        case (itype)
          `IT_RISING:  edge_hit = rise; // [RULE_13]
          `IT_FALLING: edge_hit = fall; // [RULE_13]
          `IT_BOTH:    edge_hit = rise | fall; // [RULE_13]
          default:     edge_hit = 1'b0; // [RULE_18]
        endcase
      end
      assign event_vec[g] = edge_hit;
    end
  endgenerate

  // status cleared by reading it; a new event in the same cycle wins
  always @* begin
    clear_vec = 16'h0000;
    if (RD && port_hit && offset == `OFS_INT_STATUS) begin
      clear_vec = port_mask;
    end
    status_next = (status_reg & ~clear_vec) | event_vec; // [RULE_19]
  end

  // register file writes, port form and pin form share the storage
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      output_value_reg  <= 16'h0000;
      dm0_reg           <= 16'h0000; // [RULE_21]
      dm1_reg           <= 16'h0000;
      dm2_reg           <= 16'h0000;
      bypass_reg        <= 16'h0000;
      bidir_enable_reg  <= 16'h0000;
      sio_regulated_reg <= 16'h0000;
      it0_reg           <= 16'h0000;
      it1_reg           <= 16'h0000;
      status_reg        <= 16'h0000;
      init_done_reg     <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (!init_done_reg) begin
        // straps are taken once, just after release, not during reset
        init_done_reg <= 1'b1;
        dm0_reg <= {2'b00, {6{RESET_MODE_B[0]}}, {8{RESET_MODE_A[0]}}}; // [RULE_17]
        dm1_reg <= {2'b00, {6{RESET_MODE_B[1]}}, {8{RESET_MODE_A[1]}}}; // [RULE_17]
        dm2_reg <= {2'b00, {6{RESET_MODE_B[2]}}, {8{RESET_MODE_A[2]}}}; // [RULE_17]
      end else if (WR && port_hit) begin
        case (offset)
          `OFS_OUTPUT_VALUE: begin
            output_value_reg <= (output_value_reg & ~port_mask) | ({WDATA, WDATA} & port_mask); // [RULE_15]
          end
          `OFS_DM_BIT0: begin
            dm0_reg <= (dm0_reg & ~(port_mask & ~usb_mask)) | ({WDATA, WDATA} & port_mask & ~usb_mask); // [RULE_12]
          end
          `OFS_DM_BIT1: begin
            dm1_reg <= (dm1_reg & ~(port_mask & ~usb_mask)) | ({WDATA, WDATA} & port_mask & ~usb_mask); // [RULE_12]
          end
          `OFS_DM_BIT2: begin
            dm2_reg <= (dm2_reg & ~(port_mask & ~usb_mask)) | ({WDATA, WDATA} & port_mask & ~usb_mask); // [RULE_12]
          end
          `OFS_BYPASS: begin
            bypass_reg <= (bypass_reg & ~port_mask) | ({WDATA, WDATA} & port_mask); // [RULE_16]
          end
          `OFS_BIDIR_ENABLE: begin
            bidir_enable_reg <= (bidir_enable_reg & ~port_mask) | ({WDATA, WDATA} & port_mask); // [RULE_16]
          end
          `OFS_SIO_REGULATED: begin
            sio_regulated_reg <= (sio_regulated_reg & ~port_mask) | ({WDATA, WDATA} & port_mask);
          end
          default: begin
            init_done_reg <= 1'b1;
          end
        endcase
      end else if (WR && pin_hit) begin
        // pin form gathers one pin's bits, all but the regulated bit, in a single write
        output_value_reg[pin_index] <= WDATA[`PF_OUT_BIT]; // [RULE_16]
        dm0_reg[pin_index]          <= WDATA[`PF_DM_LSB]; // [RULE_01]
        dm1_reg[pin_index]          <= WDATA[`PF_DM_LSB + 1];
        dm2_reg[pin_index]          <= WDATA[`PF_DM_LSB + 2];
        bypass_reg[pin_index]       <= WDATA[`PF_BYP_BIT];
        bidir_enable_reg[pin_index] <= WDATA[`PF_BIE_BIT];
        it0_reg[pin_index]          <= WDATA[`PF_IT_LSB];
        it1_reg[pin_index]          <= WDATA[`PF_IT_LSB + 1];
      end
    end
  end

  // read mux, answered in the following cycle
  always @* begin
    rdata_next = 8'h00;
    if (RD && port_hit) begin
      case (offset)
        `OFS_OUTPUT_VALUE:  rdata_next = port_sel ? output_value_reg[15:8] : output_value_reg[7:0];
        `OFS_DM_BIT0:       rdata_next = port_sel ? dm0_reg[15:8] : dm0_reg[7:0];
        `OFS_DM_BIT1:       rdata_next = port_sel ? dm1_reg[15:8] : dm1_reg[7:0];
        `OFS_DM_BIT2:       rdata_next = port_sel ? dm2_reg[15:8] : dm2_reg[7:0];
        `OFS_BYPASS:        rdata_next = port_sel ? bypass_reg[15:8] : bypass_reg[7:0];
        `OFS_BIDIR_ENABLE:  rdata_next = port_sel ? bidir_enable_reg[15:8] : bidir_enable_reg[7:0];
        `OFS_PIN_STATE:     rdata_next = port_sel ? sync2_reg[15:8] : sync2_reg[7:0]; // [RULE_15]
        `OFS_INT_STATUS:    rdata_next = port_sel ? status_reg[15:8] : status_reg[7:0];
        `OFS_SIO_REGULATED: rdata_next = port_sel ? sio_regulated_reg[15:8] : sio_regulated_reg[7:0];
        default:            rdata_next = 8'h00;
      endcase
    end else if (RD && pin_hit) begin
      rdata_next = {it1_reg[pin_index], it0_reg[pin_index], bidir_enable_reg[pin_index],
                    bypass_reg[pin_index], dm2_reg[pin_index], dm1_reg[pin_index],
                    dm0_reg[pin_index], output_value_reg[pin_index]}; // [RULE_16]
    end
  end

  // drive decode for the general and special pins
  generate
    for (g = 0; g < `USB_PIN_FIRST; g = g + 1) begin : pin_drive
      wire       val      = bypass_reg[g] ? ROUTED_OUT[g] : output_value_reg[g]; // [RULE_07]
      wire       oe_off   = bidir_enable_reg[g] && !ROUTED_OE[g];
      wire [2:0] set_mode = {dm2_reg[g], dm1_reg[g], dm0_reg[g]}; // [RULE_01]
      wire [2:0] mode     = oe_off ? `DM_DIGITAL_HIZ : set_mode; // [RULE_20]
      wire       no_res   = (g < 8) && sio_regulated_reg[g];
      reg        hi;
      reg        lo;
      reg        pu;
      reg        pd;
      // each mode picks the driver used for a one and for a zero
      always @* begin
        hi = 1'b0;
        lo = 1'b0;
        pu = 1'b0;
        pd = 1'b0;
        case (mode)
          `DM_PULL_UP: begin
            pu = val; // [RULE_03]
            lo = ~val;
          end
          `DM_PULL_DOWN: begin
            hi = val; // [RULE_03]
            pd = ~val;
          end
          `DM_OD_LOW: begin
            lo = ~val; // [RULE_04]
          end
          `DM_OD_HIGH: begin
            hi = val; // [RULE_05]
          end
          `DM_STRONG: begin
            hi = val; // [RULE_06]
            lo = ~val;
          end
          `DM_PULL_BOTH: begin
            pu = val; // [RULE_06]
            pd = ~val;
          end
          default: begin
            hi = 1'b0; // [RULE_02]
          end
        endcase
      end
      // regulated special pins have no resistors; the pulled side floats
      assign hi_next[g]   = hi;
      assign lo_next[g]   = lo;
      assign pu_next[g]   = pu & ~no_res; // [RULE_08]
      assign pd_next[g]   = pd & ~no_res; // [RULE_08]
      assign ibuf_next[g] = (mode != `DM_ANALOG_HIZ); // [RULE_21]
    end
  endgenerate

  // usb-capable pair: drive enable in bit 0, pull-up enable in bit 1
  generate
    for (g = `USB_PIN_FIRST; g < 16; g = g + 1) begin : usb_drive
      wire val    = bypass_reg[g] ? ROUTED_OUT[g] : output_value_reg[g]; // [RULE_07]
      wire drv_en = dm0_reg[g]; // [RULE_09]
      wire pu_en  = dm1_reg[g]; // [RULE_09]
      wire io_use = !USB_MODE; // usb core owns the pins [RULE_11]
      assign lo_next[g]   = io_use & ~val; // [RULE_10]
      assign hi_next[g]   = io_use & val & drv_en; // [RULE_10]
      assign pu_next[g]   = io_use & val & ~drv_en & pu_en; // [RULE_10]
      assign pd_next[g]   = 1'b0;
      assign ibuf_next[g] = 1'b1;
    end
  endgenerate

  // all outputs registered; drive changes lag settings by one cycle
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA        <= 8'h00;
      STRONG_HIGH  <= 16'h0000;
      STRONG_LOW   <= 16'h0000;
      PULL_UP      <= 16'h0000;
      PULL_DOWN    <= 16'h0000;
      INPUT_BUF_EN <= 16'h0000;
      PIN_STATE    <= 16'h0000;
      IRQ          <= 2'b00;
    end else begin
      RDATA        <= rdata_next;
      STRONG_HIGH  <= hi_next;
      STRONG_LOW   <= lo_next;
      PULL_UP      <= pu_next;
      PULL_DOWN    <= pd_next;
      INPUT_BUF_EN <= ibuf_next;
      PIN_STATE    <= sync2_reg;
      IRQ[0]       <= |status_next[7:0]; // [RULE_14]
      IRQ[1]       <= |status_next[15:8]; // [RULE_14]
    end
  end

endmodule

// >>> gpio_pin_drive_control_props.sv
`timescale 1ns/1ns
module gpio_drive_props (
  input wire        CLOCK,
  input wire        RST_N,
  input wire        RD,
  input wire [7:0]  RDATA,
  input wire        USB_MODE,
  input wire [15:0] PIN_IN,
  input wire [15:0] STRONG_HIGH,
  input wire [15:0] STRONG_LOW,
  input wire [15:0] PULL_UP,
  input wire [15:0] PULL_DOWN,
  input wire [15:0] INPUT_BUF_EN,
  input wire [15:0] PIN_STATE,
  input wire [1:0]  IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // pins pulled or driven toward each rail
  wire [15:0] hi_side = STRONG_HIGH | PULL_UP;
  wire [15:0] lo_side = STRONG_LOW | PULL_DOWN;
  wire [15:0] clash   = (hi_side & lo_side) | (STRONG_HIGH & PULL_UP) | (STRONG_LOW & PULL_DOWN);
  one_side_a: assert property (clash == 16'h0000)
    else $error("pin driven two ways at once");
  hiz_no_drive_a: assert property ((~INPUT_BUF_EN[13:0] & (hi_side[13:0] | lo_side[13:0])) == 14'h0000)
    else $error("analog high-z pin has a driver on");
  usb_off_a: assert property (USB_MODE [*3] |-> {hi_side[15:14], lo_side[15:14]} == 4'h0)
    else $error("usb pin driven in usb operation");
  usb_no_pd_a: assert property (PULL_DOWN[15:14] == 2'b00)
    else $error("usb pin pulled down");
  rd_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its cycle");
  irq_a_cause_a: assert property (RST_N [*5] ##0 $rose(IRQ[0]) |-> $past(PIN_IN[7:0], 3) != $past(PIN_IN[7:0], 4))
    else $error("port a request without pin edge");
  irq_b_cause_a: assert property (RST_N [*5] ##0 $rose(IRQ[1]) |-> $past(PIN_IN[15:8], 3) != $past(PIN_IN[15:8], 4))
    else $error("port b request without pin edge");
  pin_sync_a: assert property ((RST_N && $stable(PIN_IN)) [*6] |-> PIN_STATE == PIN_IN)
    else $error("pin state does not follow steady pins");
endmodule

bind gpio_pin_drive_control gpio_drive_props props (.CLOCK(CLOCK), .RST_N(RST_N), .RD(RD), .RDATA(RDATA),
  .USB_MODE(USB_MODE), .PIN_IN(PIN_IN), .STRONG_HIGH(STRONG_HIGH), .STRONG_LOW(STRONG_LOW), .PULL_UP(PULL_UP),
  .PULL_DOWN(PULL_DOWN), .INPUT_BUF_EN(INPUT_BUF_EN), .PIN_STATE(PIN_STATE), .IRQ(IRQ));

// >>> pin_load_model.sv
`timescale 1ns/1ns
module pin_load_model (
  input  wire        clk,
  input  wire [15:0] strong_high,
  input  wire [15:0] strong_low,
  input  wire [15:0] pull_up,
  input  wire [15:0] pull_down,
  input  wire [15:0] ext_en,
  input  wire [15:0] ext_val,
  output reg  [15:0] level
);
  integer i;
  initial level = 16'h0000;
  // outside driver wins; a floating pin flips so it never looks steady
  always @(posedge clk) begin
    for (i = 0; i < 16; i = i + 1) begin
      if (ext_en[i])
        level[i] <= ext_val[i];
      else if (strong_high[i] | strong_low[i])
        level[i] <= strong_high[i];
      else if (pull_up[i] | pull_down[i])
        level[i] <= pull_up[i];
      else
        level[i] <= ~level[i];
    end
  end
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb;
  reg         clock = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [7:0]  wdata = 8'h00;
  reg         wr_s = 1'b0;
  reg         rd_s = 1'b0;
  reg  [2:0]  reset_mode_a = 3'h6;
  reg  [2:0]  reset_mode_b = 3'h4;
  reg         usb_mode = 1'b0;
  reg  [15:0] routed_out = 16'h0000;
  reg  [15:0] routed_oe = 16'hffff;
  reg  [15:0] ext_en = 16'h02ff;
  reg  [15:0] ext_val = 16'h0000;
  reg  [31:0] seed = 32'h068eea41;
  reg  [7:0]  rq[$];
  reg  [7:0]  dq[$];
  reg  [4:0]  bq[$];
  reg  [4:0]  b;
  reg         snap_b = 1'b0;
  wire [15:0] ibuf;
  reg  [7:0]  n;
  reg  [7:0]  r;
  reg         rd_d = 1'b0;
  reg         snap = 1'b0;
  integer     error_cnt = 0;
  integer     checked = 0;
  integer     cycles = 0;
  integer     m, v, t, p;
  wire [7:0]  rdata;
  wire [15:0] pin_in, s_hi, s_lo, p_up, p_dn;
  wire [1:0]  irq;
  gpio_pin_drive_control dut (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .RESET_MODE_A(reset_mode_a), .RESET_MODE_B(reset_mode_b), .USB_MODE(usb_mode),
    .PIN_IN(pin_in), .ROUTED_OUT(routed_out), .ROUTED_OE(routed_oe), .STRONG_HIGH(s_hi), .STRONG_LOW(s_lo),
    .PULL_UP(p_up), .PULL_DOWN(p_dn), .INPUT_BUF_EN(ibuf), .PIN_STATE(), .IRQ(irq));
  pin_load_model load (.clk(clock), .strong_high(s_hi), .strong_low(s_lo), .pull_up(p_up), .pull_down(p_dn),
    .ext_en(ext_en), .ext_val(ext_val), .level(pin_in));
  always #2 clock = ~clock;
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // expected {strong high, strong low, pull up, pull down}
  function [3:0] drv(input [2:0] md, input vl);
    case (md)
      3'h2: drv = vl ? 4'h2 : 4'h4;
      3'h3: drv = vl ? 4'h8 : 4'h1;
      3'h4: drv = vl ? 4'h0 : 4'h4;
      3'h5: drv = vl ? 4'h8 : 4'h0;
      3'h6: drv = vl ? 4'h8 : 4'h4;
      3'h7: drv = vl ? 4'h2 : 4'h1;
      default: drv = 4'h0;
    endcase
  endfunction
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task cmp_rd(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmp_drv(input [3:0] got, input [3:0] exp);
    cmp_rd({4'h0, got}, {4'h0, exp});
  endtask
  task cmp_buf(input got, input exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // input buffer enable, sampled like the drive outputs
  task see_buf(input [3:0] pin, input e);
    begin
      repeat (3) @(posedge clock);
      bq.push_back({pin, e});
      snap_b <= 1'b1;
      @(posedge clock);
      snap_b <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clock);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clock);
      addr <= a;
      rd_s <= 1'b1;
      rq.push_back(e);
      @(posedge clock);
      rd_s <= 1'b0;
    end
  endtask
  // drive outputs settle two edges after the write
  task see(input [3:0] pin, input [3:0] e);
    begin
      repeat (3) @(posedge clock);
      dq.push_back({pin, e});
      snap <= 1'b1;
      @(posedge clock);
      snap <= 1'b0;
    end
  endtask
  task do_reset;
    begin
      rst_n <= 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
    end
  endtask
  // result watcher: oldest note against what appears
  always @(posedge clock) begin
    rd_d <= rd_s;
    if (rd_d)
      cmp_rd(rdata, rq.pop_front());
    if (snap) begin
      n = dq.pop_front();
      cmp_drv({s_hi[n[7:4]], s_lo[n[7:4]], p_up[n[7:4]], p_dn[n[7:4]]}, n[3:0]);
    end
    if (snap_b) begin
      b = bq.pop_front();
      cmp_buf(ibuf[b[4:1]], b[0]);
    end
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  initial begin
    do_reset;
    rd(8'h02, 8'hff);
    rd(8'h43, 8'h3f);
    see(4'd8, 4'h4);
    see_buf(4'd8, 1'b1);
    $display("end straps");
    for (m = 0; m < 8; m = m + 1) begin
      for (v = 0; v < 2; v = v + 1) begin
        seed = xs(seed);
        p = 4 + seed[1:0];
        wr(8'h10 | p[7:0], {4'h0, m[2:0], v[0]});
        see(p[3:0], drv(m[2:0], v[0]));
      end
    end
    see(4'd0, 4'h4);
    $display("end modes");
    routed_out <= 16'h0008;
    wr(8'h13, 8'h1c);
    see(4'd3, 4'h8);
    routed_oe <= 16'hfff7;
    wr(8'h13, 8'h2d);
    see(4'd3, 4'h0);
    routed_oe <= 16'hffff;
    see(4'd3, 4'h8);
    wr(8'h08, 8'h01);
    wr(8'h10, 8'h05);
    see(4'd0, 4'h0);
    wr(8'h10, 8'h04);
    see(4'd0, 4'h4);
    $display("end bypass bidir regulated");
    for (t = 0; t < 8; t = t + 1) begin
      wr(8'h56, {5'h00, t[2:0]});
      see(4'd14, !t[0] ? 4'h4 : t[1] ? 4'h8 : t[2] ? 4'h2 : 4'h0);
    end
    wr(8'h41, 8'h00);
    rd(8'h56, 8'h07);
    usb_mode <= 1'b1;
    see(4'd14, 4'h0);
    usb_mode <= 1'b0;
    $display("end usb pins");
    for (t = 0; t < 4; t = t + 1) begin
      wr(8'h12, {t[1:0], 6'h02});
      ext_val[2] <= 1'b1;
      repeat (6) @(posedge clock);
      rd(8'h07, {5'h00, t[0], 2'h0});
      ext_val[2] <= 1'b0;
      repeat (6) @(posedge clock);
      rd(8'h07, {5'h00, t[1], 2'h0});
    end
    wr(8'h51, 8'hc2);
    ext_val[9] <= 1'b1;
    repeat (6) @(posedge clock);
    rd(8'h47, 8'h02);
    rd(8'h07, 8'h00);
    $display("end interrupts");
    seed = xs(seed);
    r = seed[7:0];
    wr(8'h00, r);
    rd(8'h00, r);
    rd(8'h11, {4'h0, 3'h6, r[1]});
    ext_val[7:0] <= ~r;
    wr(8'h06, 8'h00);
    repeat (6) @(posedge clock);
    rd(8'h06, ~r);
    rd(8'h18, 8'h00);
    $display("end registers");
    ext_val <= 16'h0000;
    reset_mode_a <= 3'h0;
    reset_mode_b <= 3'h1;
    do_reset;
    rd(8'h10, 8'h00);
    rd(8'h41, 8'h3f);
    see(4'd0, 4'h0);
    see_buf(4'd0, 1'b0);
    see_buf(4'd8, 1'b1);
    $display("end second reset");
    tally_and_finish;
  end
endmodule
